// File: usr_pkg.sv
// usr_pkg: shared constants and types of the four-stage shift register.
// assumes: one 125 MHz apb clock domain; apb data are 32 bits wide.
package usr_pkg;

   ////////////////////////////////////////////////////////////////////
   // geometry
   localparam int STAGES = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int EDGE_W = 16;
   localparam int LEVEL_W = 5;

   ////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_CMD = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_EDGES = 12'h00c;

   ////////////////////////////////////////////////////////////////////
   // control register fields and reset value
   localparam int CTRL_W = 3;
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam int CTRL_RUN_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////
   // status register fields
   localparam int STAT_STAGE_LSB = 0;
   localparam int STAT_EMPTY_BIT = 4;
   localparam int STAT_FULL_BIT = 5;
   localparam int STAT_LEVEL_LSB = 8;

   ////////////////////////////////////////////////////////////////////
   // mode codes, {mode_sel_upper, mode_sel_lower}
   localparam logic [1:0] MODE_HOLD = 2'h0;
   localparam logic [1:0] MODE_SHR = 2'h1;
   localparam logic [1:0] MODE_SHL = 2'h2;
   localparam logic [1:0] MODE_LOAD = 2'h3;

   // one queued step: mode, two serial bits, parallel data a..d
   typedef struct packed {
      logic [1:0] mode;
      logic ser_left;
      logic ser_right;
      logic [STAGES-1:0] par;
   } usr_cmd_t;

   localparam int CMD_W = $bits(usr_cmd_t);

endpackage

// File: usr_fifo_if.sv
// usr_fifo_if: valid/ready carrier between the register block and fifo.
// assumes: both ends sit on the same pclk domain.
`timescale 1ns/1ns
interface usr_fifo_if #(
   parameter int W = 8,
   parameter int DEPTH = 16
);
   logic in_valid; // write side offers a word
   logic in_ready; // fifo has room
   logic [W-1:0] in_data;
   logic out_valid; // fifo holds a word
   logic out_ready; // reader takes the word
   logic [W-1:0] out_data;
   logic [$clog2(DEPTH):0] level; // words held

   modport fifo (
      input in_valid, in_data, out_ready,
      output in_ready, out_valid, out_data, level
   );
   modport user (
      output in_valid, in_data, out_ready,
      input in_ready, out_valid, out_data, level
   );
endinterface

// File: usr_fifo.sv
// usr_fifo: synchronous first-in first-out buffer, width and depth set
// by parameters.
// assumes: depth is a power of two; clk_en low freezes every bit.
`timescale 1ns/1ns
module usr_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // both sides of the buffer
   usr_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_CNT = (AW+1)'(1);
   localparam logic [AW-1:0] ONE_PTR = AW'(1);

   // whole state of the buffer
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] cnt;
   } usr_fifo_st_t;

   usr_fifo_st_t s_q; // registered state
   usr_fifo_st_t s_d; // next state
   logic push; // word accepted this cycle
   logic pop; // word handed out this cycle

   // flags come from the count, so full and empty never lie
   assign f.in_ready = (s_q.cnt != FULL_CNT);
   assign f.out_valid = (s_q.cnt != '0);
   assign f.out_data = s_q.mem[s_q.rptr];
   assign f.level = s_q.cnt;
   assign push = f.in_valid && f.in_ready;
   assign pop = f.out_valid && f.out_ready;

   ////////////////////////////////////////////////////////////////////
   // next state: write at wptr, read at rptr, count tracks both
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wptr] = f.in_data;
         s_d.wptr = s_q.wptr + ONE_PTR;
      end
      if (pop)
      begin
         s_d.rptr = s_q.rptr + ONE_PTR;
      end
      // push and pop together leave the count alone
      if (push && !pop)
      begin
         s_d.cnt = s_q.cnt + ONE_CNT;
      end
      else if (pop && !push)
      begin
         s_d.cnt = s_q.cnt - ONE_CNT;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

endmodule

// File: usr_shift4.sv
// usr_shift4: four-stage bidirectional shift register with apb access.
// stage outputs follow a clock pin rise three pclk edges later.
// assumes: pin inputs are asynchronous to pclk; an apb master on pclk.
//
// Contract
// - four stages, own outputs, shift both ways.
// - clear low forces every stage low.
// - clock low, clear high: stages hold. The code still steps queue words with the run bit set.
// - act only on rising clock edges. The code steps queue words without one when the run bit is set.
// - both selects high: edge loads parallel inputs.
// - upper low, lower high: shift toward last.
// - upper high, lower low: shift toward first.
// - both selects low: stages hold always. The code ignores the select pins when steps come from the queue.
`timescale 1ns/1ns
module usr_shift4
   import usr_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // register pins, asynchronous to pclk
   input wire logic shift_clk,
   input wire logic clear_n,
   input wire logic mode_sel_upper,
   input wire logic mode_sel_lower,
   input wire logic ser_left,
   input wire logic ser_right,
   input wire logic [STAGES-1:0] par_in,
   // stage outputs
   output logic first_stage_out,
   output logic second_stage_out,
   output logic third_stage_out,
   output logic last_stage_out
);

   ////////////////////////////////////////////////////////////////////
   // pin bundle layout, all pins cross through one synchroniser
   localparam int PIN_W = STAGES + 6;
   localparam int PIN_CLK = STAGES + 5;
   localparam int PIN_CLR = STAGES + 4;
   localparam int PIN_CMD_MSB = STAGES + 3;
   localparam logic [EDGE_W-1:0] EDGE_ONE = EDGE_W'(1);
   // limitation: pins are sampled, not clocked in, so every level and
   // every clock phase must last three pclk or more; a shorter pulse on
   // the clock or clear pin may be lost

   // whole state of the block
   typedef struct packed {
      logic [PIN_W-1:0] sync1; // first synchroniser stage
      logic [PIN_W-1:0] sync2; // second synchroniser stage
      logic clk_prev; // last synchronised clock level
      logic [STAGES-1:0] stages; // the four storage stages
      logic [CTRL_W-1:0] ctrl; // software control
      logic [EDGE_W-1:0] edges; // executed steps
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } usr_st_t;

   usr_st_t s_q; // registered state
   usr_st_t s_d; // next state

   ////////////////////////////////////////////////////////////////////
   // queue of software steps
   // the queue shares clk_en, so a frozen block loses no word
   usr_fifo_if #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) cmdq ();

   usr_fifo #(
      .W(CMD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_cmdq (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .f(cmdq.fifo)
   );

   ////////////////////////////////////////////////////////////////////
   // synchronised pin view; only sync2 is ever looked at
   // sync1 may be metastable, so no logic reads it; all pins share
   // one delay, which keeps data aligned with the clock pin
   logic [PIN_W-1:0] pins_raw; // raw pin bundle
   logic pin_edge; // rising edge seen on the clock pin
   logic clear_act; // pin clear or software clear
   logic from_fifo; // steps come from the queue
   usr_cmd_t pin_cmd; // step described by the pins
   usr_cmd_t cmd; // step that would run now
   logic step; // a step runs this cycle
   logic [STAGES-1:0] stage_nxt; // stage values after the step
   logic [STAGES:0] right_ext; // serial right below stage 0
   logic [STAGES:0] left_ext; // serial left above the last stage

   assign pins_raw = {shift_clk, clear_n, mode_sel_upper,
                      mode_sel_lower, ser_left, ser_right, par_in};
   assign pin_cmd = usr_cmd_t'(s_q.sync2[PIN_CMD_MSB:0]);
   // pins reach sync2 together, so data and clock stay aligned
   assign pin_edge = s_q.sync2[PIN_CLK] && !s_q.clk_prev;
   // clear from the pin or from software overrides everything
   // software clear keeps the stages at zero while its bit is set
   assign clear_act = !s_q.sync2[PIN_CLR] ||
                      s_q.ctrl[CTRL_CLR_BIT];
   assign from_fifo = s_q.ctrl[CTRL_SRC_BIT];
   // queue words and pin levels share one decoder, so both sources
   // give the same result for the same step
   assign cmd = from_fifo ? usr_cmd_t'(cmdq.out_data) : pin_cmd;

   ////////////////////////////////////////////////////////////////////
   // step decision: pin edges only, or queue words on run bit or pin edge
   // trade-off: the clock pin may also pace the queue, so software can
   // preload words and still let outside logic time every step
   always_comb
   begin
      step = 1'b0;
      if (clear_act)
      begin
         // cleared register takes no step; the queue waits
         step = 1'b0;
      end
      else if (from_fifo)
      begin
         // run bit lets the queue drain without a pin edge
         step = cmdq.out_valid &&
                (s_q.ctrl[CTRL_RUN_BIT] || pin_edge);
      end
      else
      begin
         // a clock pin held low or high never steps
         step = pin_edge;
      end
   end

   // the queue drains only as fast as steps run
   assign cmdq.out_ready = from_fifo && step;

   ////////////////////////////////////////////////////////////////////
   // per-stage next value: load, shift right, shift left or hold
   // the serial bits sit beside the end stages in right_ext and
   // left_ext, so every stage picks its neighbour by plain index
   assign right_ext = {s_q.stages, cmd.ser_right};
   assign left_ext = {cmd.ser_left, s_q.stages};

   generate
      for (genvar i = 0; i < STAGES; i++)
      begin : g_stage
         // stage i takes par[i], its lower or its upper neighbour
         assign stage_nxt[i] =
            (cmd.mode == MODE_LOAD) ? cmd.par[i] :
            (cmd.mode == MODE_SHR) ? right_ext[i] :
            (cmd.mode == MODE_SHL) ? left_ext[i+1] :
            s_q.stages[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // apb decode
   // map: CTRL rw (source, soft clear, run), CMD write-only push,
   // STATUS and EDGES read-only; every transfer takes one wait state,
   // a CMD write into a full queue waits until a step frees a slot
   logic access; // access phase of a transfer
   logic hit_ctrl; // address decodes
   logic hit_cmd;
   logic hit_stat;
   logic hit_edge;
   logic bad; // unmapped or read-only target of a write
   logic cmd_stall; // queue full, hold the write off
   logic [DATA_W-1:0] rd_mux; // read value

   assign access = psel && penable;
   assign hit_ctrl = (paddr == OFF_CTRL);
   assign hit_cmd = (paddr == OFF_CMD);
   assign hit_stat = (paddr == OFF_STATUS);
   assign hit_edge = (paddr == OFF_EDGES);
   assign bad = !(hit_ctrl || hit_cmd || hit_stat || hit_edge) ||
                (pwrite && (hit_stat || hit_edge));
   // back-pressure: a full queue stretches the access phase
   assign cmd_stall = pwrite && hit_cmd && !cmdq.in_ready;

   // read multiplexer, unused bits read as zero
   always_comb
   begin
      rd_mux = '0;
      if (hit_ctrl)
      begin
         rd_mux[CTRL_W-1:0] = s_q.ctrl;
      end
      else if (hit_stat)
      begin
         rd_mux[STAT_STAGE_LSB +: STAGES] = s_q.stages;
         rd_mux[STAT_EMPTY_BIT] = !cmdq.out_valid;
         rd_mux[STAT_FULL_BIT] = !cmdq.in_ready;
         rd_mux[STAT_LEVEL_LSB +: LEVEL_W] = cmdq.level;
      end
      else if (hit_edge)
      begin
         rd_mux[EDGE_W-1:0] = s_q.edges;
      end
      else
      begin
         // command port and holes read as zero
         rd_mux = '0;
      end
   end

   // push at the completing edge; room was checked when ready rose
   assign cmdq.in_valid = access && s_q.pready && pwrite &&
                          hit_cmd && !s_q.pslverr;
   assign cmdq.in_data = pwdata[CMD_W-1:0];

   ////////////////////////////////////////////////////////////////////
   // next state of the block
   always_comb
   begin
      s_d = s_q;
      // two-stage synchroniser and clock history
      s_d.sync1 = pins_raw;
      s_d.sync2 = s_q.sync1;
      s_d.clk_prev = s_q.sync2[PIN_CLK];

      // storage stages
      // a pin step that meets a clear is lost, not delayed; a queue word waits
      if (clear_act)
      begin
         s_d.stages = '0;
      end
      else if (step)
      begin
         s_d.stages = stage_nxt;
         // wraps at 16 bits; hold steps are counted as well
         s_d.edges = s_q.edges + EDGE_ONE;
      end

      // apb: one wait state, then ready for one cycle
      // the answer is built a cycle ahead so prdata and pslverr leave
      // flip-flops together with pready
      if (access && !s_q.pready)
      begin
         if (!cmd_stall)
         begin
            s_d.pready = 1'b1;
            s_d.pslverr = bad;
            s_d.prdata = pwrite ? '0 : rd_mux;
         end
      end
      else if (access && s_q.pready)
      begin
         // completing edge: the write lands here and nowhere else
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
         if (pwrite && hit_ctrl && !s_q.pslverr)
         begin
            s_d.ctrl = pwdata[CTRL_W-1:0];
         end
      end
      else
      begin
         // idle or setup phase
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register; synchroniser resets to clear asserted so the
   // stages stay low until the pin is seen high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         // clock history starts high: a pin already high when reset
         // lifts must not look like a rising edge
         s_q.sync1[PIN_CLK] <= 1'b1;
         s_q.sync2[PIN_CLK] <= 1'b1;
         s_q.clk_prev <= 1'b1;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   // prdata keeps its last answer until the next transfer ends
   assign first_stage_out = s_q.stages[0];
   assign second_stage_out = s_q.stages[1];
   assign third_stage_out = s_q.stages[2];
   assign last_stage_out = s_q.stages[STAGES-1];
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;

endmodule

// File: usr_shift4_chk.sv
// usr_shift4_chk: assertions on the stage outputs and the apb answer.
// assumes: bound into usr_shift4 with clk_en held high.
`timescale 1ns/1ns
module usr_shift4_chk
   import usr_pkg::*;
(
   // clock, reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic pready,
   // pins
   input wire logic shift_clk,
   input wire logic clear_n,
   input wire logic mode_sel_upper,
   input wire logic mode_sel_lower,
   input wire logic ser_left,
   input wire logic ser_right,
   input wire logic [STAGES-1:0] par_in,
   // stages
   input wire logic first_stage_out,
   input wire logic second_stage_out,
   input wire logic third_stage_out,
   input wire logic last_stage_out
);
   logic [3:0] q, nx, exp_q; // stages, next value, value due
   logic [1:0] md; // mode pins, upper first
   logic clk_q, sw_q; // pin clock one pclk back; queue or soft clear on
   logic rise, ok; // pin clock rise; pin steps allowed
   assign q = {last_stage_out, third_stage_out, second_stage_out,
      first_stage_out};
   assign md = {mode_sel_upper, mode_sel_lower};
   assign rise = shift_clk & ~clk_q;
   assign ok = clear_n & ~sw_q;
   // value one pin step should give
   assign nx = md == MODE_LOAD ? par_in : md == MODE_SHR ?
      {q[2:0], ser_right} : md == MODE_SHL ? {ser_left, q[3:1]} : q;

   ////////////////////////////////////////////////////////////////////
   // control shadow: with src or soft clear set, no step described by the pins runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {clk_q, sw_q, exp_q} <= '0;
      else
      begin
         clk_q <= shift_clk;
         if (rise)
            exp_q <= nx;
         if (penable && pready && pwrite && paddr == OFF_CTRL)
            sw_q <= |pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // the pin path lags by synchronisers, so steps get five pclk
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_clr; !clear_n [*4] |-> q == 4'h0; endproperty
   a_clr: assert property (p_clr) else $error("clear missed");
   property p_low; $fell(shift_clk) && ok |-> $stable(q) [*8]; endproperty
   a_low: assert property (p_low) else $error("moved, clock low");
   property p_high; rise && ok |-> ##6 $stable(q) [*2]; endproperty
   a_high: assert property (p_high) else $error("moved twice");
   property p_load; rise && ok && md == MODE_LOAD |-> ##[1:5] q == exp_q;
   endproperty
   a_load: assert property (p_load) else $error("bad load");
   property p_shr; rise && ok && md == MODE_SHR |-> ##[1:5] q == exp_q;
   endproperty
   a_shr: assert property (p_shr) else $error("bad right shift");
   property p_shl; rise && ok && md == MODE_SHL |-> ##[1:5] q == exp_q;
   endproperty
   a_shl: assert property (p_shl) else $error("bad left shift");
   property p_hold; rise && ok && md == MODE_HOLD |=> $stable(q) [*5];
   endproperty
   a_hold: assert property (p_hold) else $error("hold moved");
   property p_rdy; pready |=> !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready too long");
   // main scenarios reached
   c_load: cover property (rise && ok && md == MODE_LOAD);
   c_shr: cover property (rise && ok && md == MODE_SHR);
   c_shl: cover property (rise && ok && md == MODE_SHL);
endmodule

bind usr_shift4 usr_shift4_chk u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .shift_clk(shift_clk),
   .clear_n(clear_n),
   .mode_sel_upper(mode_sel_upper),
   .mode_sel_lower(mode_sel_lower),
   .ser_left(ser_left),
   .ser_right(ser_right),
   .par_in(par_in),
   .first_stage_out(first_stage_out),
   .second_stage_out(second_stage_out),
   .third_stage_out(third_stage_out),
   .last_stage_out(last_stage_out)
);

// File: usr_pin_drv.sv
// usr_pin_drv: logic beside the register that drives its pins.
// assumes: tasks are called one at a time, just after a pclk edge.
`timescale 1ns/1ns
module usr_pin_drv
   import usr_pkg::*;
(
   // system clock
   input wire logic pclk,
   // pin levels toward the register
   output logic shift_clk,
   output logic clear_n,
   output logic [1:0] mode,
   output logic ser_left,
   output logic ser_right,
   output logic [STAGES-1:0] par
);
   // idle: clear off, clock low, hold mode, data low
   initial {shift_clk, clear_n, mode, ser_left, ser_right, par} = 10'h100;

   ////////////////////////////////////////////////////////////////////
   // one step; levels lead and trail the rise by four pclk or more so
   // that the synchronisers see them settled
   task automatic step(input logic [1:0] m, input logic sl,
      input logic sr, input logic [STAGES-1:0] p);
      @(posedge pclk);
      mode <= m;
      ser_left <= sl;
      ser_right <= sr;
      par <= p;
      repeat (4) @(posedge pclk);
      shift_clk <= 1'b1;
      repeat (8) @(posedge pclk);
      shift_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      // data change with the clock low must not disturb the stages
      ser_left <= ~sl;
      ser_right <= ~sr;
      par <= ~p;
   endtask

   // drive clear, then let it pass the synchronisers
   task automatic set_clear(input logic v);
      @(posedge pclk);
      clear_n <= v;
      repeat (6) @(posedge pclk);
   endtask
endmodule

// File: usr_shift4_tb_top.sv
// usr_shift4_tb_top: self-checking bench of the shift register.
// assumes: usr_pin_drv drives the pins; clk_en stays high.
`timescale 1ns/1ns
module usr_shift4_tb_top
   import usr_pkg::*;
   ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata, rd; // read data, last read
   logic pready, pslverr, er; // answer, last error
   logic sclk, clr_n, sl_w, sr_w, sl, sr; // pins, draws
   logic [1:0] mode_w, m;
   logic [3:0] par_w, q_w, p, exp_q; // pins, stages, model
   int fail_count = 0;
   int n_compared = 0;
   always #4 pclk = ~pclk;
   usr_pin_drv drv (.pclk(pclk), .shift_clk(sclk), .clear_n(clr_n),
      .mode(mode_w), .ser_left(sl_w), .ser_right(sr_w), .par(par_w));
   usr_shift4 dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .shift_clk(sclk), .clear_n(clr_n),
      .mode_sel_upper(mode_w[1]), .mode_sel_lower(mode_w[0]),
      .ser_left(sl_w), .ser_right(sr_w), .par_in(par_w),
      .first_stage_out(q_w[0]), .second_stage_out(q_w[1]),
      .third_stage_out(q_w[2]), .last_stage_out(q_w[3]));

   ////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // a slave that never answers ends the run
      if (pready !== 1'b1)
      begin
         fail_count++;
         final_report();
      end
   endtask

   // expected stages after one step
   function automatic logic [3:0] nxt(input logic [3:0] q,
      input logic [1:0] md, input logic l, input logic r,
      input logic [3:0] d);
      return md == MODE_LOAD ? d : md == MODE_SHR ? {q[2:0], r} :
         md == MODE_SHL ? {l, q[3:1]} : q;
   endfunction

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(70));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      exp_q = 4'h0;
      chk({28'h0, q_w}, 32'h0);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, {29'h0, CTRL_RST});
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, OFF_STATUS, 32'hf);
      chk({31'h0, er}, 32'h1);
      // corner table (load, left, right, hold), then random steps
      for (int i = 0; i < 44; i++)
      begin
         m = (i < 4) ? 2'(3 - i) : 2'($urandom);
         p = (i < 4) ? 4'ha : 4'($urandom);
         sl = 1'($urandom);
         sr = (i < 4) ? 1'b1 : 1'($urandom);
         drv.step(m, sl, sr, p);
         exp_q = nxt(exp_q, m, sl, sr, p);
         chk({28'h0, q_w}, {28'h0, exp_q});
      end
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd & 32'h1f3f, {27'h0, 1'b1, exp_q});
      // clear pin wins over a load edge
      drv.set_clear(1'b0);
      drv.step(MODE_LOAD, 1'b1, 1'b1, 4'hf);
      chk({28'h0, q_w}, 32'h0);
      drv.set_clear(1'b1);
      drv.step(MODE_LOAD, 1'b0, 1'b0, 4'h5);
      chk({28'h0, q_w}, 32'h5);
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, 32'h2);
      chk({28'h0, q_w}, 32'h0);
      // fill the queue while it is stalled, then drain it
      apb(1'b1, OFF_CTRL, 32'h1);
      exp_q = 4'h0;
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
         {m, sl, sr, p} = 8'($urandom);
         apb(1'b1, OFF_CMD, {24'h0, m, sl, sr, p});
         exp_q = nxt(exp_q, m, sl, sr, p);
      end
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd & 32'h1f3f, 32'h1020);
      apb(1'b1, OFF_CTRL, 32'h5);
      repeat (40) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd & 32'h1f3f, {27'h0, 1'b1, exp_q});
      // 44 random and corner rises, one load after clear, 16 queue words;
      // the rise held off by clear must not count
      apb(1'b0, OFF_EDGES, 32'h0);
      chk(rd, 32'h3d);
      apb(1'b1, OFF_CTRL, 32'h0);
      final_report();
   end
endmodule
